// ==== rtl/eepw_defs.vh ====
// Constants for the serial nonvolatile write and security register logic.
// Assumes a 10 ns system clock; included by bare name.
`ifndef EEPW_DEFS_VH
`define EEPW_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Opcodes
`define EEPW_OP_WRITE 8'h02
`define EEPW_OP_STAT 8'h05
`define EEPW_OP_LATCH_SET 8'h06
`define EEPW_OP_SECPG 8'h9b
`define EEPW_OP_SECRD 8'h77
`define EEPW_SEC_PAD 8'h00

////////////////////////////////////////////////////////////////////////////////
// Status byte fields
`define EEPW_ST_BUSY 0
`define EEPW_ST_LATCH 1

////////////////////////////////////////////////////////////////////////////////
// Geometry
`define EEPW_ADDR_W 15
`define EEPW_PAGE_BYTES 64
`define EEPW_SEC_BYTES 128
`define EEPW_ERASED 8'hff
`define EEPW_FIFO_DEPTH 8

////////////////////////////////////////////////////////////////////////////////
// Timing
`define EEPW_CLK_NS 10
`define EEPW_WR_BYTE_NS 160
`define EEPW_WR_BYTE_CYC ((`EEPW_WR_BYTE_NS + `EEPW_CLK_NS - 1) / `EEPW_CLK_NS)

`endif

// ==== rtl/eepw_fifo.v ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/100ps
`default_nettype none

module eepw_fifo #(
	parameter W = 24,
	parameter D = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire mclk_in,
	input wire resetn_in,
	// Fill side
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [W-1:0] in_data_in,
	// Drain side
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [W-1:0] out_data_out
);

reg [W-1:0] mem_r [0:D-1];
reg [AW-1:0] wp_r;
reg [AW-1:0] rp_r;
reg [AW:0] cnt_r;
wire push;
wire pop;

assign in_ready_out = (cnt_r != D[AW:0]);
assign out_valid_out = (cnt_r != {(AW+1){1'b0}});
assign out_data_out = mem_r[rp_r];
assign push = in_valid_in & in_ready_out;
assign pop = out_valid_out & out_ready_in;

always @(posedge mclk_in) begin
	if (push) begin
		mem_r[wp_r] <= in_data_in;
	end
end

always @(posedge mclk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		wp_r <= {AW{1'b0}};
		rp_r <= {AW{1'b0}};
		cnt_r <= {(AW+1){1'b0}};
	end else begin
		if (push) begin
			wp_r <= wp_r + 1'b1;
		end
		if (pop) begin
			rp_r <= rp_r + 1'b1;
		end
		if (push & ~pop) begin
			cnt_r <= cnt_r + 1'b1;
		end else if (pop & ~push) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end
end

endmodule
`default_nettype wire

// ==== rtl/eepw_core.v ====
// Serial slave port: write data, write enable, status read and the
// one-time-programmable security register, with a self-timed program cycle.
// Assumes the pins are asynchronous to mclk_in and the serial clock is far
// slower than mclk_in, so every edge is seen after synchronising.
`timescale 1ns/100ps
`default_nettype none
`include "eepw_defs.vh"

module eepw_core #(
	parameter AW = `EEPW_ADDR_W,
	parameter [15:0] BYTE_CYC = `EEPW_WR_BYTE_CYC,
	parameter [7:0] FACTORY_SEED = 8'h3c // Arbitrary value
) (
	// Clock and reset
	input wire mclk_in,
	input wire resetn_in,
	// Serial pins
	input wire cs_n_in,
	input wire sck_in,
	input wire serial_in_in,
	output reg serial_out_out,
	output reg serial_out_oe_n_out,
	// Status
	output reg write_busy_flag_out,
	output reg write_latch_flag_out
);

////////////////////////////////////////////////////////////////////////////////
// States
localparam [8:0] S_OP = 9'h001;
localparam [8:0] S_ADDR = 9'h002;
localparam [8:0] S_DATA = 9'h004;
localparam [8:0] S_SECH = 9'h008;
localparam [8:0] S_SECD = 9'h010;
localparam [8:0] S_RDH = 9'h020;
localparam [8:0] S_RDO = 9'h040;
localparam [8:0] S_STAT = 9'h080;
localparam [8:0] S_IGN = 9'h100;
localparam FW = 1 + AW + 8;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg cs_s1_r, cs_s2_r, cs_d_r;
reg sck_s1_r, sck_s2_r, sck_d_r;
reg si_s1_r, si_s2_r;
wire sck_rise = sck_s2_r & ~sck_d_r;
wire sck_fall = ~sck_s2_r & sck_d_r;
wire cs_fall = ~cs_s2_r & cs_d_r;
wire cs_rise = cs_s2_r & ~cs_d_r;

always @(posedge mclk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		cs_s1_r <= 1'b1;
		cs_s2_r <= 1'b1;
		cs_d_r <= 1'b1;
		sck_s1_r <= 1'b0;
		sck_s2_r <= 1'b0;
		sck_d_r <= 1'b0;
		si_s1_r <= 1'b0;
		si_s2_r <= 1'b0;
	end else begin
		cs_s1_r <= cs_n_in;
		cs_s2_r <= cs_s1_r;
		cs_d_r <= cs_s2_r;
		sck_s1_r <= sck_in;
		sck_s2_r <= sck_s1_r;
		sck_d_r <= sck_s2_r;
		si_s1_r <= serial_in_in;
		si_s2_r <= si_s1_r;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Storage
reg [7:0] mem_r [0:(1<<AW)-1];
reg [7:0] pbuf_r [0:`EEPW_PAGE_BYTES-1];
reg [7:0] sec_user_r [0:`EEPW_PAGE_BYTES-1];
reg [`EEPW_PAGE_BYTES-1:0] pmask_r;

// Factory half is fixed logic, so nothing can ever alter it
function [7:0] factory_byte;
	input [5:0] idx;
	begin
		factory_byte = {2'b00, idx} ^ FACTORY_SEED;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Protocol state
reg [8:0] state_r;
reg [2:0] bitcnt_r;
reg [6:0] sh_r;
reg [7:0] hdr_r;
reg [AW-1:0] addr_r;
reg [5:0] sidx_r;
reg [6:0] ridx_r;
reg [2:0] ocnt_r;
reg latch_pend_r;
reg otp_done_r;
reg prog_run_r;
reg prog_sec_r;
reg [AW-7:0] ppage_r;
reg [6:0] pidx_r;
reg [15:0] wcnt_r;
wire [7:0] rx_byte = {sh_r, si_s2_r};
wire byte_done = sck_rise & (bitcnt_r == 3'h7);
wire whole_bytes = (bitcnt_r == 3'h0);

// Program path through the FIFO
wire fifo_in_ready;
wire fifo_out_valid;
wire [FW-1:0] fifo_out_data;
wire pend_byte = prog_run_r & ~pidx_r[6] & pmask_r[pidx_r[5:0]];
wire [FW-1:0] fifo_in_data = {prog_sec_r, ppage_r, pidx_r[5:0], pbuf_r[pidx_r[5:0]]};
wire wr_ready = (wcnt_r == 16'h0000);
wire wr_pop = fifo_out_valid & wr_ready;
wire prog_end = prog_run_r & pidx_r[6] & ~fifo_out_valid & wr_ready;

wire [7:0] status_byte = {6'h00, write_latch_flag_out, write_busy_flag_out};
wire [7:0] sec_byte = ridx_r[6] ? factory_byte(ridx_r[5:0]) : sec_user_r[ridx_r[5:0]];
wire [7:0] tx_byte = (state_r == S_STAT) ? status_byte : sec_byte;

eepw_fifo #(
	.W(FW),
	.D(`EEPW_FIFO_DEPTH),
	.AW(3)
) u_fifo (
	.mclk_in(mclk_in),
	.resetn_in(resetn_in),
	.in_valid_in(pend_byte),
	.in_ready_out(fifo_in_ready),
	.in_data_in(fifo_in_data),
	.out_valid_out(fifo_out_valid),
	.out_ready_in(wr_ready),
	.out_data_out(fifo_out_data)
);

////////////////////////////////////////////////////////////////////////////////
// Page buffer, filled only by the command decoder
always @(posedge mclk_in) begin
	if (byte_done & (state_r == S_DATA)) begin
		pbuf_r[addr_r[5:0]] <= rx_byte;
	end else if (byte_done & (state_r == S_SECD)) begin
		pbuf_r[sidx_r] <= rx_byte;
	end
end

// Main array writes come out of the FIFO at the self-timed byte rate
always @(posedge mclk_in) begin
	if (wr_pop & ~fifo_out_data[FW-1]) begin
		mem_r[fifo_out_data[FW-2:8]] <= fifo_out_data[7:0];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Command decoder
integer i;
always @(posedge mclk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		state_r <= S_IGN;
		bitcnt_r <= 3'h0;
		sh_r <= 7'h00;
		hdr_r <= 8'h00;
		addr_r <= {AW{1'b0}};
		sidx_r <= 6'h00;
		ridx_r <= 7'h00;
		ocnt_r <= 3'h0;
		latch_pend_r <= 1'b0;
		pmask_r <= {`EEPW_PAGE_BYTES{1'b0}};
		serial_out_out <= 1'b0;
		serial_out_oe_n_out <= 1'b1;
	end else if (cs_s2_r) begin
		// Deselected: output released, partial commands dropped
		serial_out_oe_n_out <= 1'b1;
		state_r <= S_IGN;
		latch_pend_r <= 1'b0;
	end else if (cs_fall) begin
		state_r <= S_OP;
		bitcnt_r <= 3'h0;
		ocnt_r <= 3'h0;
		hdr_r <= 8'h00;
		latch_pend_r <= 1'b0;
	end else begin
		if (sck_rise) begin
			sh_r <= rx_byte[6:0];
			bitcnt_r <= bitcnt_r + 3'h1;
		end
		if (sck_fall & ((state_r == S_STAT) | (state_r == S_RDO))) begin
			serial_out_out <= tx_byte[3'h7 - ocnt_r];
			serial_out_oe_n_out <= 1'b0;
			ocnt_r <= ocnt_r + 3'h1;
			if (ocnt_r == 3'h7) begin
				ridx_r <= ridx_r + 7'h01;
			end
		end
		if (byte_done) begin
			case (state_r)
			S_OP: begin
				latch_pend_r <= 1'b0;
				hdr_r <= 8'h00;
				if (rx_byte == `EEPW_OP_STAT) begin
					state_r <= S_STAT;
				end else if (write_busy_flag_out) begin
					state_r <= S_IGN;
				end else if (rx_byte == `EEPW_OP_LATCH_SET) begin
					latch_pend_r <= 1'b1;
					state_r <= S_IGN;
				end else if (rx_byte == `EEPW_OP_WRITE) begin
					state_r <= write_latch_flag_out ? S_ADDR : S_IGN;
					pmask_r <= {`EEPW_PAGE_BYTES{1'b0}};
				end else if (rx_byte == `EEPW_OP_SECPG) begin
					state_r <= otp_done_r ? S_IGN : S_SECH;
					pmask_r <= {`EEPW_PAGE_BYTES{1'b0}};
					sidx_r <= 6'h00;
				end else if (rx_byte == `EEPW_OP_SECRD) begin
					state_r <= S_RDH;
				end else begin
					state_r <= S_IGN;
				end
			end
			S_ADDR: begin
				hdr_r <= hdr_r + 8'h01;
				if (hdr_r == 8'h00) begin
					addr_r[AW-1:8] <= rx_byte[AW-9:0];
				end else begin
					addr_r[7:0] <= rx_byte;
					state_r <= S_DATA;
				end
			end
			S_DATA: begin
				pmask_r[addr_r[5:0]] <= 1'b1;
				addr_r[5:0] <= addr_r[5:0] + 6'h01;
			end
			S_SECH: begin
				hdr_r <= hdr_r + 8'h01;
				if (rx_byte != `EEPW_SEC_PAD) begin
					state_r <= S_IGN;
				end else if (hdr_r == 8'h01) begin
					state_r <= S_SECD;
				end
			end
			S_SECD: begin
				pmask_r[sidx_r] <= 1'b1;
				sidx_r <= sidx_r + 6'h01;
			end
			S_RDH: begin
				hdr_r <= hdr_r + 8'h01;
				if (rx_byte != `EEPW_SEC_PAD) begin
					state_r <= S_IGN;
				end else if (hdr_r == 8'h01) begin
					state_r <= S_RDO;
					ridx_r <= 7'h00;
					ocnt_r <= 3'h0;
				end
			end
			default: begin
				state_r <= state_r;
			end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Program engine and flags
// The decoder's chip select rise is seen here in the same cycle via cs_rise,
// before the decoder drops its state, so both look at the same command.
wire start_wr = cs_rise & whole_bytes & (state_r == S_DATA) & (|pmask_r);
wire start_sec = cs_rise & whole_bytes & (state_r == S_SECD) & (|pmask_r);

always @(posedge mclk_in or negedge resetn_in) begin
	if (!resetn_in) begin
		write_busy_flag_out <= 1'b0;
		write_latch_flag_out <= 1'b0;
		otp_done_r <= 1'b0;
		prog_run_r <= 1'b0;
		prog_sec_r <= 1'b0;
		ppage_r <= {(AW-6){1'b0}};
		pidx_r <= 7'h00;
		wcnt_r <= 16'h0000;
		for (i = 0; i < `EEPW_PAGE_BYTES; i = i + 1) begin
			sec_user_r[i] <= `EEPW_ERASED;
		end
	end else begin
		if (start_wr | start_sec) begin
			prog_run_r <= 1'b1;
			write_busy_flag_out <= 1'b1;
			prog_sec_r <= start_sec;
			ppage_r <= start_sec ? {(AW-6){1'b0}} : addr_r[AW-1:6];
			pidx_r <= 7'h00;
			if (start_sec) begin
				otp_done_r <= 1'b1;
			end
		end else if (prog_end) begin
			prog_run_r <= 1'b0;
			write_busy_flag_out <= 1'b0;
			if (!prog_sec_r) begin
				write_latch_flag_out <= 1'b0;
			end
		end else if (cs_rise & whole_bytes & latch_pend_r) begin
			write_latch_flag_out <= 1'b1;
		end
		// Walk the page mask; a full FIFO stalls the walk
		if (prog_run_r & ~pidx_r[6] & (~pend_byte | fifo_in_ready)) begin
			pidx_r <= pidx_r + 7'h01;
		end
		if (wr_pop) begin
			wcnt_r <= BYTE_CYC - 16'h0001;
			if (fifo_out_data[FW-1]) begin
				sec_user_r[fifo_out_data[13:8]] <= fifo_out_data[7:0];
			end
		end else if (!wr_ready) begin
			wcnt_r <= wcnt_r - 16'h0001;
		end
	end
end

endmodule
`default_nettype wire

// ==== verif/eepw_core_chk.sv ====
// Checker on the serial pins and status flags of the core.
// Assumes one clock domain; bound to the core below.
`timescale 1ns/100ps
`default_nettype none
module eepw_core_chk #(
	parameter [15:0] BYTE_CYC = 16'h0010
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Pins and flags
	input wire logic cs_n_in,
	input wire logic sck_in,
	input wire logic serial_out_out,
	input wire logic serial_out_oe_n_out,
	input wire logic write_busy_flag_out,
	input wire logic write_latch_flag_out
);
	wire logic bsy = write_busy_flag_out;
	wire logic latch = write_latch_flag_out;
	wire logic oen = serial_out_oe_n_out;
	logic [15:0] run_r;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);
	////////////////
	// Busy length; slack covers the buffer pipe
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			run_r <= 16'h0000;
		else
			run_r <= bsy ? run_r + 16'h0001 : 16'h0000;
	end
	sequence cs_idle;
		cs_n_in [*6];
	endsequence
	sequence prog_end;
		$fell(bsy);
	endsequence
	////////////////
	busy_rise_a: assert property ($rose(bsy) |-> $past(cs_n_in) && $past(cs_n_in, 2))
		else $error("busy inside frame");
	latch_clear_a: assert property (prog_end |-> !latch)
		else $error("latch kept");
	latch_fall_a: assert property ($fell(latch) |-> prog_end)
		else $error("latch fell early");
	latch_rise_a: assert property ($rose(latch) |-> !bsy && !$past(bsy))
		else $error("latch set while busy");
	busy_len_a: assert property (prog_end |-> run_r >= BYTE_CYC && run_r <= 64 * BYTE_CYC + 24)
		else $error("bad busy length");
	oe_idle_a: assert property (cs_idle |-> oen)
		else $error("driven while idle");
	oe_start_a: assert property ($fell(oen) |-> !cs_n_in && !$past(cs_n_in, 4))
		else $error("enabled off frame");
	out_edge_a: assert property ($changed(serial_out_out) && !oen |-> !$past(sck_in, 3))
		else $error("output off clock fall");
endmodule
bind eepw_core eepw_core_chk #(.BYTE_CYC(BYTE_CYC)) chk_i (.mclk_in(mclk_in),
	.resetn_in(resetn_in), .cs_n_in(cs_n_in), .sck_in(sck_in),
	.serial_out_out(serial_out_out), .serial_out_oe_n_out(serial_out_oe_n_out),
	.write_busy_flag_out(write_busy_flag_out), .write_latch_flag_out(write_latch_flag_out));
`default_nettype wire

// ==== verif/eepw_host.sv ====
// Host serial master model: mode 0, most significant bit first.
// Assumes its tasks are called from one process only.
`timescale 1ns/100ps
`default_nettype none
module eepw_host (
	// Clock
	input wire logic mclk_in,
	// Serial pins
	output logic cs_n_out,
	output logic sck_out,
	output logic serial_in_out,
	input wire logic sdo_in
);
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		serial_in_out = 1'b0;
	end
	////////////////
	// Half period of 8 cycles gives the 160 ns serial clock
	task automatic w(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic sel();
		w(8);
		cs_n_out = 1'b0;
	endtask
	// Clock stands still between frames; released data shows its inverse
	task automatic dsel();
		w(8);
		cs_n_out = 1'b1;
		serial_in_out = ~serial_in_out;
		w(8);
	endtask
	// Fewer than 8 bits makes an aborted byte
	task automatic sh(input logic [7:0] d, input int n, output logic [7:0] q);
		q = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			serial_in_out = d[i];
			w(8);
			sck_out = 1'b1;
			q[i] = sdo_in;
			w(8);
			sck_out = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ==== verif/eepw_core_tb.sv ====
// Bench: random writes, status polls and security register traffic.
// Assumes the host model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module eepw_core_tb;
	localparam logic [7:0] SEED = 8'h5a; // Arbitrary value
	logic mclk_in = 1'b0;
	logic resetn_in = 1'b0;
	wire cs_n, sck, serial_in, so, oe_n, busy, latch;
	int err_count = 0;
	int check_count = 0;
	int bcnt = 0;
	logic oe_seen = 1'b0;
	logic [7:0] q;
	logic [7:0] exp_m [128];
	logic [7:0] wd [80];
	always #5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		bcnt <= bcnt + int'(busy);
		oe_seen <= oe_seen | ~oe_n;
	end
	eepw_core #(.BYTE_CYC(16'h0010), .FACTORY_SEED(SEED)) DUT (.mclk_in(mclk_in),
		.resetn_in(resetn_in), .cs_n_in(cs_n), .sck_in(sck), .serial_in_in(serial_in),
		.serial_out_out(so), .serial_out_oe_n_out(oe_n), .write_busy_flag_out(busy),
		.write_latch_flag_out(latch));
	eepw_host h (.mclk_in(mclk_in), .cs_n_out(cs_n), .sck_out(sck), .serial_in_out(serial_in),
		.sdo_in(oe_n ? ~so : so));
	////////////////
	function automatic int pgm(input int n);
		return 16 * (n > 64 ? 64 : n);
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Header bytes, then n data bytes: 1 stores them, 2 reads and compares, 3 keeps write data
	task automatic fr(input logic [23:0] hd, input int nh, input int n, input int md);
		logic [7:0] d;
		h.sel();
		for (int i = nh - 1; i >= 0; i--)
			h.sh(hd[i*8 +: 8], 8, q);
		for (int k = 0; k < n; k++) begin
			d = md == 2 ? 8'h00 : 8'($urandom);
			h.sh(d, 8, q);
			if (md == 1)
				exp_m[k % 64] = d;
			if (md == 3)
				wd[k] = d;
			if (md == 2)
				chk("security byte", exp_m[k], q);
		end
		if (n > 0)
			bcnt = 0;
		h.dsel();
	endtask
	task automatic st(input logic [7:0] e);
		fr(24'h000500, 2, 0, 0);
		chk("status", e, q);
	endtask
	task automatic idle();
		q = 8'h01;
		for (int i = 0; i < 30 && q[0] === 1'b1; i++)
			fr(24'h000500, 2, 0, 0);
	endtask
	////////////////
	initial begin
		int n [4] = '{1, 3, 64, 70};
		logic [14:0] a;
		logic [7:0] pg [64];
		void'($urandom(32'hc3ef));
		for (int k = 0; k < 128; k++)
			exp_m[k] = k < 64 ? 8'hff : {2'b00, 6'(k - 64)} ^ SEED;
		h.w(2);
		resetn_in = 1'b1;
		h.w(6);
		st(8'h00);
		h.sel();
		h.sh(8'h06, 5, q);
		h.dsel();
		st(8'h00);
		fr({8'h02, 1'b0, 15'($urandom)}, 3, 2, 0);
		chk("busy cycles", 8'h00, 8'(bcnt));
		foreach (n[i]) begin
			fr(24'h000006, 1, 0, 0);
			st(8'h02);
			chk("latch pin", 8'h01, {7'h00, latch});
			a = 15'($urandom);
			for (int k = 0; k < 64; k++)
				pg[k] = DUT.mem_r[{a[14:6], 6'(k)}];
			fr({8'h02, 1'b0, a}, 3, n[i], 3);
			for (int k = 0; k < n[i]; k++)
				pg[6'(a[5:0] + k)] = wd[k];
			if (n[i] > 60) begin
				st(8'h03);
				oe_seen = 1'b0;
				fr(24'h770000, 3, 0, 0);
				chk("output while busy", 8'h00, {7'h00, oe_seen});
			end
			idle();
			st(8'h00);
			chk("latch pin", 8'h00, {7'h00, latch});
			// Mask walk covers the whole page, so a late last byte adds up to one pass
			chk("busy length", 8'h01, {7'h00, bcnt >= pgm(n[i]) && bcnt <= pgm(n[i]) + 88});
			for (int k = 0; k < 64; k++)
				chk("page byte", pg[k], DUT.mem_r[{a[14:6], 6'(k)}]);
		end
		fr(24'h770000, 3, 2, 2);
		fr(24'h9b0100, 3, 2, 0);
		chk("bad header busy", 8'h00, 8'(bcnt));
		fr(24'h9b0000, 3, 66, 1);
		chk("program busy", 8'h01, {7'h00, bcnt > 0});
		idle();
		fr(24'h9b0000, 3, 4, 0);
		chk("reprogram busy", 8'h00, 8'(bcnt));
		fr(24'h770000, 3, 128, 2);
		h.w(8);
		chk("released", 8'h01, {7'h00, oe_n});
		close_out();
	end
	// About 60k cycles expected; stop at 90k
	initial begin
		#900000;
		err_count++;
		close_out();
	end
endmodule
`default_nettype wire
